// ==== dv/usd_channel_asserts.sv ====
`timescale 1ns/10ps
module usd_channel_asserts (
   // clock and resets
   input wire logic clk,
   input wire logic resetn,
   input wire logic chan_reset,
   // apb
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   // pins and state
   input wire usd_pkg::usd_modem_in_t modem_in,
   input wire usd_pkg::usd_line_out_t line_out,
   input wire logic bus_mode68,
   input wire logic continuous_variant,
   input wire logic alert_drive_select,
   input wire logic alert_o,
   input wire logic alert_oe,
   input wire logic alert_req_n,
   input wire logic [15:0] baud_divisor,
   input wire logic loopback_active
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   wire rd_msr = psel && penable && !pwrite && paddr == usd_pkg::OFF_MODEM_STATUS;
   wire wr_acc = psel && penable && pwrite && pstrb[0];
   // read data was latched at setup, so the pins of that cycle are compared
   a_ring_pin: assert property (rd_msr && !$past(loopback_active) |->
      prdata[6] == !$past(modem_in.bell_signal_n)) else $error("ring status wrong");
   a_cd_pin: assert property (rd_msr && !$past(loopback_active) |->
      prdata[7] == !$past(modem_in.carrier_detect_n)) else $error("carrier status wrong");
   a_div_low: assert property (wr_acc && paddr == usd_pkg::OFF_DIVISOR_LOW |=>
      baud_divisor[7:0] == $past(pwdata[7:0])) else $error("divisor low wrong");
   a_div_hold: assert property (chan_reset && !wr_acc |=> $stable(baud_divisor))
      else $error("divisor moved on pin reset");
   a_line_rst: assert property (chan_reset [*2] |=> line_out == usd_pkg::RST_LINE_OUT)
      else $error("line outputs not reset");
   a_loop_lines: assert property (loopback_active [*2] |->
      line_out.tx && line_out.rts_n && line_out.dtr_n) else $error("loopback lines wrong");
   a_alert_68: assert property (bus_mode68 |-> !alert_oe && alert_req_n)
      else $error("alert wrong in 68 mode");
   a_alert_drv: assert property (!bus_mode68 && (continuous_variant || alert_drive_select)
      |-> alert_oe && !alert_o) else $error("alert not driven low");
   a_alert_tri: assert property (chan_reset ##1
      (!bus_mode68 && !continuous_variant && !alert_drive_select) |-> !alert_oe)
      else $error("alert not floated");
   c_loop: cover property (rd_msr && loopback_active);
   c_chan: cover property (chan_reset ##1 !chan_reset);
   c_div: cover property (wr_acc && paddr == usd_pkg::OFF_DIVISOR_HIGH);
endmodule // usd_channel_asserts
bind usd_channel usd_channel_asserts u_usd_channel_asserts (.clk(clk), .resetn(resetn),
   .chan_reset(chan_reset), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .modem_in(modem_in), .line_out(line_out),
   .bus_mode68(bus_mode68), .continuous_variant(continuous_variant),
   .alert_drive_select(alert_drive_select), .alert_o(alert_o), .alert_oe(alert_oe),
   .alert_req_n(alert_req_n), .baud_divisor(baud_divisor), .loopback_active(loopback_active));

// ==== dv/usd_channel_tb_top.sv ====
`timescale 1ns/10ps
module usd_channel_tb_top;
   logic clk, resetn, chan_reset, psel, penable, pwrite, pready, pslverr, err;
   logic bus_mode68, continuous_variant, alert_drive_select, alert_o, alert_oe, alert_req_n;
   logic loopback_active;
   logic [7:0] paddr, v;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0] pstrb, want;
   logic [15:0] baud_divisor;
   usd_pkg::usd_modem_in_t modem_in;
   usd_pkg::usd_line_out_t line_out;
   int errors, compares, seed, mdl[10];
   usd_modem_peer u_usd_modem_peer (.clk(clk), .want(want), .modem_in(modem_in));
   usd_channel u_usd_channel (.clk(clk), .resetn(resetn), .chan_reset(chan_reset),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .modem_in(modem_in),
      .line_out(line_out), .bus_mode68(bus_mode68), .continuous_variant(continuous_variant),
      .alert_drive_select(alert_drive_select), .alert_o(alert_o), .alert_oe(alert_oe),
      .alert_req_n(alert_req_n), .baud_divisor(baud_divisor), .loopback_active(loopback_active));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic print_verdict();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= ($random(seed) & 32'hffff_ff00) | {24'h00_0000, d};
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
      rdat = prdata;
      err = pslverr;
      if (n >= 20) errors++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // loopback feeds the upper nibble from modem control, else inverted pins
   function automatic logic [7:0] msr_hi();
      logic [3:0] m;
      m = mdl[4][4] ? {mdl[4][3], mdl[4][2], mdl[4][0], mdl[4][1]} :
                      ~{want[0], want[1], want[2], want[3]};
      return {m, 4'h0};
   endfunction
   task automatic mdl_reset(input bit pwr);
      for (int i = 0; i < 8; i++) mdl[i] = (i == 2) ? 1 : (i == 5) ? 'h60 : (i == 7) ? 'hff : 0;
      if (pwr) mdl[8] = 1;
      if (pwr) mdl[9] = 0;
   endtask
   task automatic dump();
      for (int i = 0; i < 10; i++) begin
         xfer(1'b0, 8'(i * 4), 8'h00, 4'hf);
         if (i == 6) begin
            chk(rdat & 32'h0000_00f0, msr_hi());
            xfer(1'b0, 8'h18, 8'h00, 4'hf);
            chk(rdat, msr_hi());
         end else chk(rdat, mdl[i]);
      end
      chk(baud_divisor, {mdl[9][7:0], mdl[8][7:0]});
   endtask
   initial begin
      seed = 32'hbc76;
      {resetn, chan_reset, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {bus_mode68, continuous_variant, alert_drive_select} = 3'h0;
      want = 4'h5;
      mdl_reset(1);
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      dump();
      chk(line_out, 5'h1e);
      for (int i = 0; i < 10; i++) begin
         v = $random(seed);
         if (i == 4) v = v & 8'h0f;
         if (i != 5 && i != 6) xfer(1'b1, 8'(i * 4), v, 4'hf);
         if (i != 2 && i != 5 && i != 6) mdl[i] = v;
      end
      xfer(1'b1, 8'h1c, 8'h5a, 4'h0);
      dump();
      chk(line_out, {!mdl[3][6], !mdl[4][1], !mdl[4][0], 2'h2});
      // old pin levels kept so the change flags can be predicted
      v = {4'h0, want};
      want <= $random(seed);
      repeat (3) @(posedge clk);
      xfer(1'b0, 8'h18, 8'h00, 4'hf);
      chk(rdat[3:0], {v[0] ^ want[0], ~v[1] & want[1], v[2] ^ want[2], v[3] ^ want[3]});
      dump();
      // pins move under the channel reset, so flags raised there must be cleared
      want <= $random(seed);
      chan_reset <= 1'b1;
      repeat (3) @(posedge clk);
      chan_reset <= 1'b0;
      mdl_reset(0);
      xfer(1'b0, 8'h18, 8'h00, 4'hf);
      chk(rdat, msr_hi());
      dump();
      chk(line_out, 5'h1e);
      for (int k = 0; k < 3; k++) begin
         v = (k == 0) ? 8'h1c : (k == 1) ? 8'h13 : 8'h00;
         xfer(1'b1, 8'h10, v, 4'hf);
         mdl[4] = v;
         dump();
         chk({loopback_active, line_out.rts_n, line_out.dtr_n, line_out.tx}, {k != 2, 3'h7});
      end
      for (int k = 0; k < 8; k++) begin
         {bus_mode68, continuous_variant, alert_drive_select} <= 3'(k);
         chan_reset <= 1'b1;
         repeat (2) @(posedge clk);
         chan_reset <= 1'b0;
         @(posedge clk);
         chk({alert_oe, alert_req_n, alert_o}, {!k[2] && k[1:0] != 0, 2'h2});
      end
      {bus_mode68, continuous_variant, alert_drive_select} <= 3'h0;
      xfer(1'b0, 8'h3c, 8'h00, 4'hf);
      chk({rdat[30:0], err}, 32'h0000_0001);
      // a second power-up mid-run must restore the divisor
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      mdl_reset(1);
      dump();
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      print_verdict();
   end
endmodule // usd_channel_tb_top

// ==== dv/usd_modem_peer.sv ====
`timescale 1ns/10ps
module usd_modem_peer (
   // clock and requested levels
   input wire logic clk,
   input wire logic [3:0] want,
   // modem pins
   output usd_pkg::usd_modem_in_t modem_in
);
   // pins move only after an edge, never in mid-cycle
   initial modem_in = 4'hf;
   always @(posedge clk) modem_in <= want;
endmodule // usd_modem_peer

// ==== rtl/usd_channel.sv ====
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module usd_channel (
   // clock and resets
   input wire logic clk,
   input wire logic resetn,
   input wire logic chan_reset,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // modem inputs
   input wire usd_pkg::usd_modem_in_t modem_in,
   // line outputs
   output usd_pkg::usd_line_out_t line_out,
   // alert pin straps and drive
   input wire logic bus_mode68,
   input wire logic continuous_variant,
   input wire logic alert_drive_select,
   output logic alert_o,
   output logic alert_oe,
   output logic alert_req_n,
   // channel state
   output logic [15:0] baud_divisor,
   output logic loopback_active
);

   function automatic logic usd_hit(input logic [7:0] addr, input logic [7:0] off);
      usd_hit = (addr == off);
   endfunction

   logic [7:0] event_enable_reg_q;
   logic [7:0] fifo_control_reg_q;
   logic [7:0] line_control_reg_q;
   logic [7:0] modem_control_reg_q;
   logic [7:0] line_status_reg_q;
   logic [7:0] scratch_pad_reg_q;
   logic [7:0] divisor_low_byte_q;
   logic [7:0] divisor_high_byte_q;
   logic [3:0] msr_delta_q;
   logic [3:0] msr_delta_d;
   logic [3:0] msr_prev_q;
   logic primed_q;
   logic [31:0] prdata_q;
   usd_pkg::usd_line_out_t line_q;
   usd_pkg::usd_line_out_t line_d;
   logic alert_q;

   // bus decode
   wire setup_ph = psel & ~penable;
   wire access_ph = psel & penable;
   wire hit_ier = usd_hit(paddr, usd_pkg::OFF_EVENT_ENABLE);
   wire hit_fcr = usd_hit(paddr, usd_pkg::OFF_FIFO_CONTROL);
   wire hit_isr = usd_hit(paddr, usd_pkg::OFF_EVENT_SOURCE);
   wire hit_lcr = usd_hit(paddr, usd_pkg::OFF_LINE_CONTROL);
   wire hit_mcr = usd_hit(paddr, usd_pkg::OFF_MODEM_CONTROL);
   wire hit_lsr = usd_hit(paddr, usd_pkg::OFF_LINE_STATUS);
   wire hit_msr = usd_hit(paddr, usd_pkg::OFF_MODEM_STATUS);
   wire hit_spr = usd_hit(paddr, usd_pkg::OFF_SCRATCH_PAD);
   wire hit_dll = usd_hit(paddr, usd_pkg::OFF_DIVISOR_LOW);
   wire hit_dlm = usd_hit(paddr, usd_pkg::OFF_DIVISOR_HIGH);
   wire mapped = hit_ier | hit_fcr | hit_isr | hit_lcr | hit_mcr | hit_lsr | hit_msr |
                 hit_spr | hit_dll | hit_dlm;
   // only lane 0 carries register data; upper lanes are ignored
   wire wr_ok = access_ph & pwrite & pstrb[0];
   wire [7:0] wbyte = pwdata[7:0];
   wire wr_ier = wr_ok & hit_ier;
   wire wr_fcr = wr_ok & hit_fcr;
   wire wr_lcr = wr_ok & hit_lcr;
   wire wr_mcr = wr_ok & hit_mcr;
   wire wr_lsr = wr_ok & hit_lsr;
   wire wr_msr = wr_ok & hit_msr;
   wire wr_spr = wr_ok & hit_spr;
   wire wr_dll = wr_ok & hit_dll;
   wire wr_dlm = wr_ok & hit_dlm;
   wire rd_msr = access_ph & ~pwrite & hit_msr;

   // loopback and upper modem status
   wire loop_on = modem_control_reg_q[usd_pkg::MCR_LOOPBACK];
   wire [3:0] pins_inv = ~{modem_in.carrier_detect_n, modem_in.bell_signal_n,
                           modem_in.dsr_n, modem_in.cts_n};
   wire [3:0] loop_bits = {modem_control_reg_q[usd_pkg::MCR_CD_LOOP],
                           modem_control_reg_q[usd_pkg::MCR_RI_LOOP],
                           modem_control_reg_q[usd_pkg::MCR_DTR],
                           modem_control_reg_q[usd_pkg::MCR_RTS]};
   wire [3:0] msr_hi = loop_on ? loop_bits : pins_inv;

   // change flags; ring flag only on the trailing edge of ringing
   wire [3:0] msr_change = msr_hi ^ msr_prev_q;
   wire ri_trail = msr_prev_q[usd_pkg::HI_RI] & ~msr_hi[usd_pkg::HI_RI];
   wire [3:0] delta_raw = {msr_change[usd_pkg::HI_CD], ri_trail,
                           msr_change[usd_pkg::HI_DSR], msr_change[usd_pkg::HI_CTS]};
   // first cycle after power-up compares against a constant, so it is masked
   wire [3:0] delta_set = delta_raw & {4{primed_q}};
   // a read clears only the flags it actually returned, so late events survive
   wire [3:0] delta_clr = rd_msr ? prdata_q[3:0] : 4'h0;

   always_comb begin
      if (chan_reset) begin
         msr_delta_d = usd_pkg::RST_MSR_DELTA;
      end else if (wr_msr) begin
         msr_delta_d = wbyte[3:0] | delta_set;
      end else begin
         msr_delta_d = (msr_delta_q & ~delta_clr) | delta_set;
      end
   end

   // read mux
   wire [7:0] msr_val = {msr_hi, msr_delta_q};
   wire [7:0] rd_byte = hit_ier ? event_enable_reg_q :
                        hit_fcr ? fifo_control_reg_q :
                        hit_isr ? usd_pkg::RST_EVENT_SOURCE :
                        hit_lcr ? line_control_reg_q :
                        hit_mcr ? modem_control_reg_q :
                        hit_lsr ? line_status_reg_q :
                        hit_msr ? msr_val :
                        hit_spr ? scratch_pad_reg_q :
                        hit_dll ? divisor_low_byte_q :
                        hit_dlm ? divisor_high_byte_q :
                        8'h00;

   // line outputs; loopback parks the modem outputs and tx at idle
   always_comb begin
      line_d = usd_pkg::RST_LINE_OUT;
      if (!chan_reset) begin
         line_d.tx = loop_on | ~line_control_reg_q[usd_pkg::LCR_BREAK];
         line_d.rts_n = loop_on | ~modem_control_reg_q[usd_pkg::MCR_RTS];
         line_d.dtr_n = loop_on | ~modem_control_reg_q[usd_pkg::MCR_DTR];
      end
   end

   // alert pin: no event source lives in this block, so nothing is ever pending
   wire pending = ~usd_pkg::RST_EVENT_SOURCE[usd_pkg::ISR_NONE];
   wire mode16 = ~bus_mode68;
   wire alert_drive = continuous_variant | alert_drive_select |
                      modem_control_reg_q[usd_pkg::MCR_CD_LOOP];

   // control registers, returned to their reset values by both resets
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         event_enable_reg_q <= usd_pkg::RST_EVENT_ENABLE;
         fifo_control_reg_q <= usd_pkg::RST_FIFO_CONTROL;
         line_control_reg_q <= usd_pkg::RST_LINE_CONTROL;
         modem_control_reg_q <= usd_pkg::RST_MODEM_CONTROL;
         line_status_reg_q <= usd_pkg::RST_LINE_STATUS;
         scratch_pad_reg_q <= usd_pkg::RST_SCRATCH_PAD;
      end else if (chan_reset) begin
         event_enable_reg_q <= usd_pkg::RST_EVENT_ENABLE;
         fifo_control_reg_q <= usd_pkg::RST_FIFO_CONTROL;
         line_control_reg_q <= usd_pkg::RST_LINE_CONTROL;
         modem_control_reg_q <= usd_pkg::RST_MODEM_CONTROL;
         line_status_reg_q <= usd_pkg::RST_LINE_STATUS;
         scratch_pad_reg_q <= usd_pkg::RST_SCRATCH_PAD;
      end else begin
         if (wr_ier) begin
            event_enable_reg_q <= wbyte;
         end
         if (wr_fcr) begin
            fifo_control_reg_q <= wbyte;
         end
         if (wr_lcr) begin
            line_control_reg_q <= wbyte;
         end
         if (wr_mcr) begin
            modem_control_reg_q <= wbyte;
         end
         if (wr_lsr) begin
            line_status_reg_q <= wbyte;
         end
         if (wr_spr) begin
            scratch_pad_reg_q <= wbyte;
         end
      end
   end

   // divisor bytes: power-up only, the channel reset pin leaves them alone
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         divisor_low_byte_q <= usd_pkg::RST_DIVISOR_LOW;
         divisor_high_byte_q <= usd_pkg::RST_DIVISOR_HIGH;
      end else begin
         if (wr_dll) begin
            divisor_low_byte_q <= wbyte;
         end
         if (wr_dlm) begin
            divisor_high_byte_q <= wbyte;
         end
      end
   end

   // modem status tracking
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         msr_delta_q <= usd_pkg::RST_MSR_DELTA;
         msr_prev_q <= usd_pkg::RST_MSR_PREV;
         primed_q <= 1'b0;
      end else begin
         msr_delta_q <= msr_delta_d;
         msr_prev_q <= msr_hi;
         primed_q <= 1'b1;
      end
   end

   // read data is sampled in the setup cycle so the access phase needs no wait
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup_ph) begin
         prdata_q <= {24'h00_0000, rd_byte};
      end
   end

   // registered pin outputs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         line_q <= usd_pkg::RST_LINE_OUT;
         alert_q <= 1'b0;
      end else begin
         line_q <= line_d;
         alert_q <= mode16 & pending & ~chan_reset;
      end
   end

   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = access_ph & ~mapped;
   assign line_out = line_q;
   assign alert_o = alert_q;
   assign alert_oe = mode16 & alert_drive;
   assign alert_req_n = ~(bus_mode68 & pending);
   assign baud_divisor = {divisor_high_byte_q, divisor_low_byte_q};
   assign loopback_active = loop_on;

endmodule // usd_channel

// ==== rtl/usd_pkg.sv ====
package usd_pkg;
   // register byte addresses on the APB window
   localparam logic [7:0] OFF_EVENT_ENABLE = 8'h00;
   localparam logic [7:0] OFF_FIFO_CONTROL = 8'h04;
   localparam logic [7:0] OFF_EVENT_SOURCE = 8'h08;
   localparam logic [7:0] OFF_LINE_CONTROL = 8'h0c;
   localparam logic [7:0] OFF_MODEM_CONTROL = 8'h10;
   localparam logic [7:0] OFF_LINE_STATUS = 8'h14;
   localparam logic [7:0] OFF_MODEM_STATUS = 8'h18;
   localparam logic [7:0] OFF_SCRATCH_PAD = 8'h1c;
   localparam logic [7:0] OFF_DIVISOR_LOW = 8'h20;
   localparam logic [7:0] OFF_DIVISOR_HIGH = 8'h24;

   // reset values
   localparam logic [7:0] RST_EVENT_ENABLE = 8'h00;
   localparam logic [7:0] RST_FIFO_CONTROL = 8'h00;
   localparam logic [7:0] RST_EVENT_SOURCE = 8'h01;
   localparam logic [7:0] RST_LINE_CONTROL = 8'h00;
   localparam logic [7:0] RST_MODEM_CONTROL = 8'h00;
   localparam logic [7:0] RST_LINE_STATUS = 8'h60;
   localparam logic [7:0] RST_SCRATCH_PAD = 8'hff;
   localparam logic [7:0] RST_DIVISOR_LOW = 8'h01;
   localparam logic [7:0] RST_DIVISOR_HIGH = 8'h00;
   localparam logic [3:0] RST_MSR_DELTA = 4'h0;
   localparam logic [3:0] RST_MSR_PREV = 4'h0;

   // modem control field positions
   localparam int unsigned MCR_DTR = 0;
   localparam int unsigned MCR_RTS = 1;
   localparam int unsigned MCR_RI_LOOP = 2;
   localparam int unsigned MCR_CD_LOOP = 3;
   localparam int unsigned MCR_LOOPBACK = 4;
   // line control field positions
   localparam int unsigned LCR_BREAK = 6;
   // event source: bit 0 set means nothing pending
   localparam int unsigned ISR_NONE = 0;
   // positions inside the upper modem status nibble (msr bits 7..4)
   localparam int unsigned HI_CTS = 0;
   localparam int unsigned HI_DSR = 1;
   localparam int unsigned HI_RI = 2;
   localparam int unsigned HI_CD = 3;

   typedef struct packed {
      logic cts_n;
      logic dsr_n;
      logic bell_signal_n;
      logic carrier_detect_n;
   } usd_modem_in_t;

   typedef struct packed {
      logic tx;
      logic rts_n;
      logic dtr_n;
      logic rx_ready_n;
      logic tx_ready_n;
   } usd_line_out_t;

   localparam usd_line_out_t RST_LINE_OUT = '{tx: 1'b1, rts_n: 1'b1, dtr_n: 1'b1,
                                               rx_ready_n: 1'b1, tx_ready_n: 1'b0};
endpackage
